// ===== hdl/sfp_consts.svh
// timing counts and command constants for the sector flash host controller
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH
`define SFP_CLK_MHZ 200
`define SFP_STROBE_NS 40
`define SFP_STROBE_CYC ((`SFP_STROBE_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_SETUP_NS 20
`define SFP_SETUP_CYC ((`SFP_SETUP_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_ACCESS_NS 90
`define SFP_ACCESS_CYC ((`SFP_ACCESS_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_GAP_US 150
`define SFP_GAP_CYC (`SFP_GAP_US * `SFP_CLK_MHZ)
`define SFP_SAFE_GAP_CYC (`SFP_GAP_CYC / 2)
`define SFP_CYCLE_MS 10
`define SFP_CYCLE_CYC (`SFP_CYCLE_MS * 1000 * `SFP_CLK_MHZ)
`define SFP_PWRUP_MS 5
`define SFP_PWRUP_CYC (`SFP_PWRUP_MS * 1000 * `SFP_CLK_MHZ)
`define SFP_ERASED_BYTE 8'hFF
`define SFP_POLL_BIT 7
`define SFP_TOGGLE_BIT 6
`define SFP_CMD1_ADDR 19'h05555
`define SFP_CMD1_DATA 8'hAA
`define SFP_CMD2_ADDR 19'h02AAA
`define SFP_CMD2_DATA 8'h55
`define SFP_CMD3_ADDR 19'h05555
`define SFP_CMD3_DATA 8'hA0
`define SFP_CNT_W 24
`endif

// ===== hdl/sfp_host.sv
// host controller driving a byte-wide sector flash through its pins
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_host
  import sfp_pkg::*;
#(
  parameter int unsigned GAP_CYC = `SFP_SAFE_GAP_CYC,
  parameter int unsigned CYCLE_CYC = `SFP_CYCLE_CYC,
  parameter int unsigned PWRUP_CYC = `SFP_PWRUP_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire sfp_op_t op_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic last_i,
  output logic busy_o,
  output logic byte_req_o,
  output logic done_o,
  output logic timeout_o,
  output logic [7:0] rdata_o,
  output logic [18:0] address_lines_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  output logic wr_strobe_n_o,
  input wire logic [7:0] data_pins_i,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe_n_o
);
  sfp_state_t state_q;
  logic [`SFP_CNT_W-1:0] cnt_q;
  logic [`SFP_CNT_W-1:0] wait_q;
  logic [`SFP_CNT_W-1:0] pwr_q;
  logic [1:0] cmd_idx_q;
  logic prog_q;
  logic last_q;
  logic poll_rd_q;
  logic [7:0] data_s;
  logic [7:0] last_byte_q;
  logic [18:0] last_addr_q;
  logic [18:0] sector_q;
  logic [18:0] cur_addr;
  logic [7:0] cur_data;
  logic cmd_phase;
  sfp_sync #(.W(8)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(data_pins_i),
    .q_o(data_s)
  );
  // guard prefix steps come before the first sector byte when requested
  assign cmd_phase = (op_i == SFP_OP_WGUARD) && (cmd_idx_q != 2'd3);
  always_comb begin
    cur_addr = addr_i;
    cur_data = wdata_i;
    if (cmd_phase) begin
      case (cmd_idx_q)
        2'd0: begin
          cur_addr = `SFP_CMD1_ADDR;
          cur_data = `SFP_CMD1_DATA;
        end
        2'd1: begin
          cur_addr = `SFP_CMD2_ADDR;
          cur_data = `SFP_CMD2_DATA;
        end
        default: begin
          cur_addr = `SFP_CMD3_ADDR;
          cur_data = `SFP_CMD3_DATA;
        end
      endcase
    end
  end
  // power-up hold off: nothing is programmed before the supply delay elapses
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_q <= '0;
    end else if (pwr_q < PWRUP_CYC[`SFP_CNT_W-1:0]) begin
      pwr_q <= pwr_q + 1'b1;
    end
  end
  // main sequencer: one state walks every pin transaction
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SFP_IDLE;
      cnt_q <= '0;
      wait_q <= '0;
      cmd_idx_q <= 2'd0;
      prog_q <= 1'b0;
      last_q <= 1'b0;
      poll_rd_q <= 1'b0;
      last_byte_q <= 8'h00;
      last_addr_q <= '0;
      sector_q <= '0;
      busy_o <= 1'b0;
      byte_req_o <= 1'b0;
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      rdata_o <= 8'h00;
      address_lines_o <= '0;
      chip_sel_n_o <= 1'b1;
      out_en_n_o <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      data_pins_o <= 8'h00;
      data_pins_oe_n_o <= 1'b1;
    end else begin
      byte_req_o <= 1'b0;
      done_o <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      case (state_q)
        SFP_IDLE: begin
          chip_sel_n_o <= 1'b1;
          out_en_n_o <= 1'b1;
          wr_strobe_n_o <= 1'b1;
          data_pins_oe_n_o <= 1'b1;
          if (start_i && (op_i == SFP_OP_READ)) begin
            address_lines_o <= addr_i;
            prog_q <= 1'b0;
            busy_o <= 1'b1;
            cnt_q <= '0;
            state_q <= SFP_SETUP;
          end else if (start_i && pwr_q >= PWRUP_CYC[`SFP_CNT_W-1:0]) begin
            prog_q <= 1'b1;
            cmd_idx_q <= 2'd0;
            sector_q <= {addr_i[18:8], 8'h00};
            busy_o <= 1'b1;
            timeout_o <= 1'b0;
            cnt_q <= '0;
            state_q <= SFP_SETUP;
          end
        end
        SFP_SETUP: begin
          chip_sel_n_o <= 1'b0;
          if (!prog_q) begin
            out_en_n_o <= 1'b0;
            data_pins_oe_n_o <= 1'b1;
            cnt_q <= '0;
            state_q <= SFP_PULSE;
          end else begin
            // keep sector bits fixed for every sector byte of the load period; guard prefix steps drive their own addresses
            address_lines_o <= cmd_phase ? cur_addr : {sector_q[18:8], cur_addr[7:0]};
            data_pins_o <= cur_data;
            data_pins_oe_n_o <= 1'b0;
            out_en_n_o <= 1'b1;
            if (cnt_q >= `SFP_SETUP_CYC) begin
              cnt_q <= '0;
              wr_strobe_n_o <= 1'b0;
              state_q <= SFP_PULSE;
            end
          end
        end
        SFP_PULSE: begin
          // strobe held well beyond the glitch filter width
          if (!prog_q && cnt_q >= `SFP_ACCESS_CYC + 2) begin
            rdata_o <= data_s;
            out_en_n_o <= 1'b1;
            chip_sel_n_o <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state_q <= SFP_IDLE;
          end else if (prog_q && cnt_q >= `SFP_STROBE_CYC) begin
            wr_strobe_n_o <= 1'b1;
            cnt_q <= '0;
            state_q <= SFP_HOLD;
          end
        end
        SFP_HOLD: begin
          chip_sel_n_o <= 1'b1;
          data_pins_oe_n_o <= 1'b1;
          cnt_q <= '0;
          if (cmd_phase) begin
            cmd_idx_q <= cmd_idx_q + 2'd1;
            state_q <= SFP_GAP;
          end else begin
            last_byte_q <= data_pins_o;
            last_addr_q <= address_lines_o;
            last_q <= last_i;
            byte_req_o <= !last_i;
            state_q <= SFP_GAP;
          end
        end
        SFP_GAP: begin
          // next byte must fall well within the device load window
          if (last_q) begin
            if (cnt_q >= GAP_CYC[`SFP_CNT_W-1:0] * 2) begin
              cnt_q <= '0;
              wait_q <= '0;
              state_q <= SFP_POLL;
            end
          end else if (cmd_phase || start_i) begin
            cnt_q <= '0;
            state_q <= SFP_SETUP;
          end else if (cnt_q >= GAP_CYC[`SFP_CNT_W-1:0]) begin
            // device window still open: a poll read now could see stale array data
            timeout_o <= 1'b1;
            last_q <= 1'b1;
          end
        end
        SFP_POLL: begin
          // poll the last loaded byte until its top bit matches the loaded data
          wait_q <= wait_q + 1'b1;
          address_lines_o <= last_addr_q;
          chip_sel_n_o <= 1'b0;
          if (cnt_q == `SFP_ACCESS_CYC + 2) begin
            out_en_n_o <= 1'b1;
            poll_rd_q <= 1'b1;
          end else if (cnt_q == 0) begin
            out_en_n_o <= 1'b0;
          end
          if (cnt_q >= `SFP_ACCESS_CYC + 4) begin
            cnt_q <= '0;
          end
          if (poll_rd_q) begin
            poll_rd_q <= 1'b0;
            if (data_s[`SFP_POLL_BIT] == last_byte_q[`SFP_POLL_BIT]) begin
              state_q <= SFP_DONE;
            end else if (wait_q >= CYCLE_CYC[`SFP_CNT_W-1:0] * 2) begin
              timeout_o <= 1'b1;
              state_q <= SFP_DONE;
            end
          end
        end
        SFP_DONE: begin
          chip_sel_n_o <= 1'b1;
          out_en_n_o <= 1'b1;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          last_q <= 1'b0;
          state_q <= SFP_IDLE;
        end
        default: begin
          state_q <= SFP_IDLE;
        end
      endcase
    end
  end
  // never drive the data pins while output enable is low
  AST_NO_CONTENTION: assert property (@(posedge mclk_i) disable iff (rst_i)
    !out_en_n_o |-> data_pins_oe_n_o) else $error("data driven during read");
  // strobe low only with select low and output enable high
  AST_LOAD_GATES: assert property (@(posedge mclk_i) disable iff (rst_i)
    !wr_strobe_n_o |-> (!chip_sel_n_o && out_en_n_o)) else $error("bad load gating");
  sequence s_strobe_fall;
    $fell(wr_strobe_n_o);
  endsequence
  // strobe pulse is long enough to pass the glitch filter
  AST_STROBE_WIDTH: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_strobe_fall |-> !wr_strobe_n_o [*8]) else $error("strobe too short");
  // data stays driven across the rising strobe edge
  AST_DATA_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(wr_strobe_n_o) |-> !data_pins_oe_n_o) else $error("data released early");
  // sector bits steady between byte loads
  AST_SECTOR_STEADY: assert property (@(posedge mclk_i) disable iff (rst_i)
    ($fell(wr_strobe_n_o) && !cmd_phase && prog_q) |->
      address_lines_o[18:8] == sector_q[18:8]) else $error("sector moved");
  // no programming request before the supply delay ends
  AST_PWRUP: assert property (@(posedge mclk_i) disable iff (rst_i)
    !wr_strobe_n_o |-> pwr_q >= PWRUP_CYC[`SFP_CNT_W-1:0]) else $error("early program");
  // gap before next strobe stays below the load window
  AST_GAP_BOUND: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == SFP_GAP && !last_q) |-> cnt_q <= GAP_CYC[`SFP_CNT_W-1:0])
    else $error("gap exceeded");
  // busy drops only in the same cycle that completion is reported
  AST_DONE_BUSY: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(busy_o) |-> done_o) else $error("busy fell without done");
endmodule

// ===== hdl/sfp_pkg.sv
// types for the sector flash host controller
package sfp_pkg;
  typedef enum logic [1:0] {SFP_OP_READ, SFP_OP_PROG, SFP_OP_WGUARD} sfp_op_t;
  typedef enum logic [2:0] {
    SFP_IDLE, SFP_SETUP, SFP_PULSE, SFP_HOLD, SFP_GAP, SFP_POLL, SFP_DONE
  } sfp_state_t;
endpackage

// ===== hdl/sfp_sync.sv
// two-flop synchroniser bank for the pin inputs
`timescale 1ns/1ps
module sfp_sync #(
  parameter int W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // first flop feeds only the second
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ===== verif/sfp_flash_model.sv
// behavioural model of the byte-wide sector flash seen by the host controller
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_flash_model #(
  parameter realtime WIN_NS = 400.0,
  parameter realtime WC_NS = 1000.0
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_drv_o
);
  logic [7:0] mem [int];
  logic [18:0] qa [$];
  logic [7:0] qd [$];
  logic [18:0] la_q = '0;
  logic [7:0] last_d = 8'h00;
  logic guard_q = 1'b0;
  logic busy_q = 1'b0;
  logic tog_q = 1'b0;
  int gen = 0;
  realtime tfall = 0;
  // output enable low blocks writes, so a strobe with it low never loads
  wire wl_n = ce_n_i | we_n_i | ~oe_n_i;

  // erase then program; a guard prefix is stripped and sets the guard
  task automatic commit();
    int s;
    s = 0;
    if (qa.size() >= 3 && qa[0] == `SFP_CMD1_ADDR && qd[0] == `SFP_CMD1_DATA &&
        qa[1] == `SFP_CMD2_ADDR && qd[1] == `SFP_CMD2_DATA &&
        qa[2] == `SFP_CMD3_ADDR && qd[2] == `SFP_CMD3_DATA) begin
      s = 3;
      guard_q = 1'b1;
    end
    busy_q = 1'b1;
    last_d = qd[qd.size()-1];
    if (qa.size() > s && (!guard_q || s == 3)) begin
      for (int i = 0; i < 256; i++) mem[{qa[s][18:8], 8'(i)}] = `SFP_ERASED_BYTE;
      for (int i = s; i < qa.size(); i++) mem[qa[i]] = qd[i];
    end
    qa.delete();
    qd.delete();
    #WC_NS;
    busy_q = 1'b0;
  endtask

  // address on the later falling edge of select or strobe
  always @(negedge wl_n) begin
    tfall = $realtime;
    gen++;
    if (!busy_q) la_q = addr_i;
  end

  // data on the first rising edge; short pulses are dropped as noise
  always @(posedge wl_n) begin
    if (!busy_q && $realtime - tfall >= 15.0) begin
      qa.push_back(la_q);
      qd.push_back(dq_i);
      fork
        begin
          automatic int my = gen;
          #WIN_NS;
          if (my == gen && !busy_q) commit();
        end
      join_none
    end
  end

  // each read start while busy flips the toggle bit
  always @(negedge oe_n_i) if (busy_q) tog_q <= ~tog_q;

  // read path: polling status while busy, array data otherwise
  assign dq_drv_o = ~ce_n_i & ~oe_n_i & we_n_i;
  always @(addr_i, oe_n_i, ce_n_i, busy_q, tog_q) begin
    if (busy_q) dq_o = {~last_d[7], tog_q, last_d[5:0]};
    else dq_o = mem.exists(addr_i) ? mem[addr_i] : `SFP_ERASED_BYTE;
  end
endmodule

// ===== verif/tb.sv
// self-checking bench for the sector flash host controller
`timescale 1ns/1ps
`include "sfp_consts.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
  import sfp_pkg::*;
  localparam int CYC = 200;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  sfp_op_t op_i = SFP_OP_READ;
  logic [18:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic last_i = 1'b0;
  logic busy_o, byte_req_o, done_o, timeout_o, dev_drv;
  logic chip_sel_n_o, out_en_n_o, wr_strobe_n_o, data_pins_oe_n_o;
  logic [7:0] rdata_o, data_pins_o, dev_dq, bus;
  logic [7:0] held_q = 8'h5A;
  logic [18:0] address_lines_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int waited = 0;

  always #2.5 mclk_i = ~mclk_i;
  // a released bus shows the inverse of its last driven value
  assign bus = dev_drv ? dev_dq : (!data_pins_oe_n_o ? data_pins_o : ~held_q);
  always @(posedge mclk_i) if (dev_drv || !data_pins_oe_n_o) held_q <= bus;
  // every load pulse keeps select low and output enable high
  always @(negedge wr_strobe_n_o) `CHK("load pins", 2'b10, {out_en_n_o, chip_sel_n_o})

  sfp_host #(.GAP_CYC(50), .CYCLE_CYC(CYC), .PWRUP_CYC(10)) i_sfp_host (
    .mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .last_i(last_i), .busy_o(busy_o), .byte_req_o(byte_req_o),
    .done_o(done_o), .timeout_o(timeout_o), .rdata_o(rdata_o),
    .address_lines_o(address_lines_o), .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o),
    .wr_strobe_n_o(wr_strobe_n_o), .data_pins_i(bus), .data_pins_o(data_pins_o),
    .data_pins_oe_n_o(data_pins_oe_n_o));
  sfp_flash_model i_sfp_flash_model (
    .ce_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o), .we_n_i(wr_strobe_n_o),
    .addr_i(address_lines_o), .dq_i(bus), .dq_o(dev_dq), .dq_drv_o(dev_drv));

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // bounded wait: 0 done, 1 byte request, 2 strobe low on addr_i, 3 idle
  // mode 2 matches the address so guard prefix strobes do not end the wait
  task automatic wait_for(input int w);
    int n;
    n = 0;
    while (!(w == 0 ? done_o === 1'b1 : w == 1 ? byte_req_o === 1'b1 :
             w == 2 ? (wr_strobe_n_o === 1'b0 && address_lines_o === addr_i) :
             busy_o === 1'b0)) begin
      @(posedge mclk_i);
      #1;
      n++;
      if (n > 5000) begin
        error_cnt++;
        $display("[FAIL] wait %0d exp %h got %h", w, 1'b1, 1'b0);
        end_sim();
      end
    end
    waited = n;
  endtask

  task automatic rd(input logic [18:0] a, input logic [7:0] e);
    op_i = SFP_OP_READ;
    addr_i = a;
    start_i = 1'b1;
    @(posedge mclk_i);
    #1;
    start_i = 1'b0;
    wait_for(0);
    `CHK("read data", e, rdata_o)
  endtask

  // one load period; stop early leaves the final byte request unanswered
  task automatic prog(input sfp_op_t op, input logic [18:0] a[$], input logic [7:0] d[$],
                      input bit stop);
    op_i = op;
    foreach (a[i]) begin
      if (i > 0) wait_for(1);
      addr_i = a[i];
      wdata_i = d[i];
      last_i = (i == a.size() - 1) && !stop;
      start_i = 1'b1;
      wait_for(2);
      start_i = 1'b0;
    end
    if (!stop) wait_for(0);
  endtask

  // early program is held off, then bytes in any order, gaps read erased
  task automatic t_load_any_order();
    op_i = SFP_OP_PROG;
    start_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    #1;
    `CHK("early busy", 1'b0, busy_o)
    prog(SFP_OP_PROG, '{19'h01280, 19'h01205, 19'h01210}, '{8'h81, 8'h05, 8'h10}, 0);
    `CHK("poll wait", 1'b1, waited >= CYC)
    `CHK("no timeout", 1'b0, timeout_o)
    rd(19'h01280, 8'h81);
    rd(19'h01205, 8'h05);
    rd(19'h01210, 8'h10);
    rd(19'h01200, 8'hFF);
    `CHK("idle pins", 4'hF, {chip_sel_n_o, out_en_n_o, wr_strobe_n_o, data_pins_oe_n_o})
  endtask

  // reprogram one byte: the rest of the sector is erased first
  task automatic t_reprogram_erases();
    prog(SFP_OP_PROG, '{19'h01205}, '{8'hA5}, 0);
    rd(19'h01205, 8'hA5);
    rd(19'h01210, 8'hFF);
  endtask

  // host goes silent after one byte: load period closes on its own
  task automatic t_gap_timeout();
    prog(SFP_OP_PROG, '{19'h03001}, '{8'h11}, 1);
    wait_for(3);
    `CHK("gap timeout", 1'b1, timeout_o)
    rd(19'h03001, 8'h11);
  endtask

  // guarded writes land, unguarded ones only run the timer
  task automatic t_guard();
    prog(SFP_OP_WGUARD, '{19'h02003}, '{8'h3C}, 0);
    rd(19'h02003, 8'h3C);
    prog(SFP_OP_PROG, '{19'h02003}, '{8'hC3}, 0);
    `CHK("guard poll", 1'b1, waited >= CYC)
    rd(19'h02003, 8'h3C);
    prog(SFP_OP_WGUARD, '{19'h02003}, '{8'h77}, 0);
    rd(19'h02003, 8'h77);
  endtask

  initial begin
    repeat (10) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    t_load_any_order();
    t_reprogram_erases();
    t_gap_timeout();
    t_guard();
    end_sim();
  end
endmodule
